// ===== rtl/rx_ep_pkg.sv
/*
 * constants shared by the receive endpoint control block: register map,
 * field positions, reset values and retry counts.
 * assumes a 16-bit register port with 4-byte-aligned byte addresses.
 */
package rx_ep_pkg;
   localparam int NUM_EP = 3;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int PAYLOAD_W = 11;
   localparam int UNLOAD_W = 14;

   // register map: endpoint n at n * 0x10, three words each
   localparam logic [ADDR_W-1:0] OFS_EP_STRIDE = 8'h10;
   localparam logic [1:0] REG_MAX_PAYLOAD = 2'h0;
   localparam logic [1:0] REG_CTRL_LOW = 2'h1;
   localparam logic [1:0] REG_CTRL_HIGH = 2'h2;

   // low control/status bits
   localparam int LOW_CLEAR_TOGGLE = 7;
   localparam int LOW_STALLED = 6;
   localparam int LOW_REQUEST = 5;
   localparam int LOW_SEND_STALL = 5;
   localparam int LOW_FLUSH = 4;
   localparam int LOW_NAK_TIMEOUT = 3;
   localparam int LOW_FAULT = 2;
   localparam int LOW_FULL = 1;
   localparam int LOW_READY = 0;

   // high control/status bits
   localparam int HIGH_AUTO_CLEAR = 7;
   localparam int HIGH_AUTO_REQUEST = 6;
   localparam int HIGH_DMA_ENABLE = 5;
   localparam int HIGH_DMA_MODE = 3;
   localparam int HIGH_TOGGLE_WE = 2;
   localparam int HIGH_TOGGLE = 1;

   // reset values
   localparam logic [PAYLOAD_W-1:0] RST_MAX_PAYLOAD = 11'h000;
   localparam logic [7:0] RST_CTRL = 8'h00;

   // failed IN attempts before the fault flag is raised
   localparam logic [1:0] ATTEMPT_LIMIT = 2'h3;
   // range of nak limit codes that enable the timeout
   localparam logic [7:0] NAK_CODE_MIN = 8'h02;
   localparam logic [7:0] NAK_CODE_MAX = 8'h10;
endpackage

// ===== rtl/rx_ep_timer_if.sv
/*
 * bundle between the endpoint register logic and one retry/timeout timer.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface rx_ep_timer_if;
   logic nak_seen;
   logic data_ok;
   logic attempt_fail;
   logic frame_tick;
   logic [7:0] nak_code;
   logic armed;
   logic restart;
   logic nak_expired;
   logic attempts_expired;

   modport ctrl (output nak_seen, data_ok, attempt_fail, frame_tick, nak_code, armed, restart,
                 input nak_expired, attempts_expired);
   modport timer (input nak_seen, data_ok, attempt_fail, frame_tick, nak_code, armed, restart,
                  output nak_expired, attempts_expired);
endinterface

// ===== rtl/rx_ep_timer.sv
/*
 * per-endpoint timer: counts frames of persisting nak answers against the
 * programmed limit, and failed IN attempts against the attempt limit.
 * assumes single-cycle event pulses from link logic on the same clock.
 */
`timescale 1ns/1ps
module rx_ep_timer
   import rx_ep_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   rx_ep_timer_if.timer tif
);
   logic nak_active;
   logic [15:0] frame_count;
   logic [1:0] attempts;
   logic [15:0] nak_frames;
   logic nak_enabled;
   logic nak_hit;
   logic attempt_hit;

   // limit is 2^(code-1) frames; codes 0, 1 and above 16 switch the timeout off
   assign nak_enabled = (tif.nak_code >= NAK_CODE_MIN) && (tif.nak_code <= NAK_CODE_MAX);
   assign nak_frames = nak_enabled ? (16'h0001 << (tif.nak_code[4:0] - 5'h01)) : 16'h0000;
   assign nak_hit = tif.armed && nak_enabled && nak_active && tif.frame_tick
                    && (frame_count + 16'h0001 >= nak_frames);
   assign attempt_hit = tif.armed && tif.attempt_fail && (attempts == ATTEMPT_LIMIT - 2'h1);

   // any data packet or a software restart ends the nak streak and attempt run
   always_ff @(posedge clk_sys) begin
      if (rst || tif.data_ok || tif.restart || nak_hit) begin
         nak_active <= 1'b0;
         frame_count <= 16'h0000;
      end else begin
         if (tif.nak_seen) begin
            nak_active <= 1'b1;
         end
         if (nak_active && tif.frame_tick) begin
            frame_count <= frame_count + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || tif.data_ok || tif.restart || attempt_hit) begin
         attempts <= 2'h0;
      end else if (tif.armed && tif.attempt_fail) begin
         attempts <= attempts + 2'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tif.nak_expired <= 1'b0;
         tif.attempts_expired <= 1'b0;
      end else begin
         tif.nak_expired <= nak_hit;
         tif.attempts_expired <= attempt_hit;
      end
   end
endmodule

// ===== rtl/rx_ep_ctrl.sv
/*
 * receive endpoint 1..3 control: payload limit, low and high control/status
 * registers, request, stall, flush, toggle, auto-clear, auto-request and dma.
 * assumes link events arrive as one-cycle pulses on clk_sys, one bit per
 * endpoint (bit 0 = endpoint 1), and a register master that never waits.
 */
`timescale 1ns/1ps
module rx_ep_ctrl
   import rx_ep_pkg::*;
#(
   parameter int EPS = NUM_EP
)
(
   input wire logic clk_sys,
   input wire logic rst,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DATA_W-1:0] reg_rdata,
   // mode and link events
   input wire logic host_mode,
   input wire logic frame_tick,
   input wire logic [EPS-1:0] ep_bulk,
   input wire logic [EPS-1:0] ep_bulk_or_int,
   input wire logic [EPS*8-1:0] nak_limit,
   input wire logic [EPS-1:0] ev_packet_rx,
   input wire logic [EPS-1:0] ev_short_packet,
   input wire logic [EPS-1:0] ev_toggle_flip,
   input wire logic [EPS-1:0] ev_stall_rx,
   input wire logic [EPS-1:0] ev_stall_tx,
   input wire logic [EPS-1:0] ev_nak_rx,
   input wire logic [EPS-1:0] ev_attempt_fail,
   input wire logic [EPS-1:0] ev_dma_done,
   input wire logic [EPS-1:0] fifo_full,
   input wire logic [EPS-1:0] fifo_read,
   input wire logic [2:0] fifo_read_bytes,
   // outputs to link, fifo and dma
   output logic [EPS-1:0] request_in_packet,
   output logic [EPS-1:0] send_stall,
   output logic [EPS-1:0] fifo_flush,
   output logic [EPS-1:0] data_toggle_bit,
   output logic [EPS-1:0] dma_request,
   output logic [EPS-1:0] endpoint_irq_flag
);
   // stored per-endpoint state, plus the combinational next read data
   logic [PAYLOAD_W-1:0] max_payload_bytes [EPS];
   logic [EPS-1:0] stalled;
   logic [EPS-1:0] request_bit;
   logic [EPS-1:0] stall_bit;
   logic [EPS-1:0] nak_timeout_flag;
   logic [EPS-1:0] data_fault;
   logic [EPS-1:0] rx_packet_ready;
   logic [EPS-1:0] auto_clear_ready;
   logic [EPS-1:0] auto_request;
   logic [EPS-1:0] dma_request_enable;
   logic [EPS-1:0] dma_interrupt_mode;
   logic [EPS-1:0] toggle;
   logic [UNLOAD_W-1:0] unloaded [EPS];
   logic [DATA_W-1:0] next_rdata;

   // address decode
   logic [1:0] sel_ep;
   logic [1:0] sel_reg;
   logic addr_ok;
   logic [EPS-1:0] wr_payload;
   logic [EPS-1:0] wr_low;
   logic [EPS-1:0] wr_high;

   // per-endpoint combinational terms
   logic [EPS-1:0] w_clear_toggle;
   logic [EPS-1:0] w_flush;
   logic [EPS-1:0] w_toggle_load;
   logic [EPS-1:0] ready_clear;
   logic [EPS-1:0] ready_fall;
   logic [EPS-1:0] full_unload;
   logic [EPS-1:0] next_ready;
   logic [EPS-1:0] nak_expired;
   logic [EPS-1:0] attempts_expired;
   logic [EPS-1:0] irq_cause;

   // endpoint n lives at n * stride; endpoint 0 and word 3 are unmapped
   function automatic logic hit(input logic [1:0] ep, input logic [1:0] rg, input int n,
                                input logic [1:0] want);
      hit = (ep == 2'(n + 1)) && (rg == want);
   endfunction

   assign sel_ep = reg_addr[5:4];
   assign sel_reg = reg_addr[3:2];
   assign addr_ok = (reg_addr[7:6] == 2'h0) && (reg_addr[1:0] == 2'h0)
                    && (sel_ep != 2'h0) && (sel_reg != 2'h3);

   genvar n;
   generate
      for (n = 0; n < EPS; n++) begin : g_ep
         rx_ep_timer_if tif ();

         // write strobes for this endpoint's three registers
         assign wr_payload[n] = reg_write && addr_ok && hit(sel_ep, sel_reg, n, REG_MAX_PAYLOAD);
         assign wr_low[n] = reg_write && addr_ok && hit(sel_ep, sel_reg, n, REG_CTRL_LOW);
         assign wr_high[n] = reg_write && addr_ok && hit(sel_ep, sel_reg, n, REG_CTRL_HIGH);

         assign w_clear_toggle[n] = wr_low[n] && reg_wdata[LOW_CLEAR_TOGGLE];
         assign w_flush[n] = wr_low[n] && reg_wdata[LOW_FLUSH];
         // the enable is only meaningful in the same write, so it never reads back set
         assign w_toggle_load[n] = wr_high[n] && reg_wdata[HIGH_TOGGLE_WE];

         // dma unloads whole 4-byte chunks, so the count may overshoot the payload
         assign full_unload[n] = fifo_read[n] && (max_payload_bytes[n] != 11'h000)
                                 && ((unloaded[n] + UNLOAD_W'(fifo_read_bytes))
                                     >= UNLOAD_W'(max_payload_bytes[n]));
         assign ready_clear[n] = (wr_low[n] && !reg_wdata[LOW_READY]) || w_flush[n]
                                 || (full_unload[n] && auto_clear_ready[n]);
         // a new packet in the same cycle keeps ready set
         assign next_ready[n] = ev_packet_rx[n] | (rx_packet_ready[n] & ~ready_clear[n]);
         assign ready_fall[n] = rx_packet_ready[n] && !next_ready[n];

         // timer hookup: armed only for host bulk/interrupt while not halted
         assign tif.nak_seen = ev_nak_rx[n];
         assign tif.data_ok = ev_packet_rx[n];
         assign tif.attempt_fail = ev_attempt_fail[n];
         assign tif.frame_tick = frame_tick;
         assign tif.nak_code = ep_bulk[n] ? nak_limit[n*8 +: 8] : 8'h00;
         assign tif.armed = host_mode && ep_bulk_or_int[n] && !nak_timeout_flag[n];
         assign tif.restart = wr_low[n] && !reg_wdata[LOW_NAK_TIMEOUT];
         assign nak_expired[n] = tif.nak_expired;
         assign attempts_expired[n] = tif.attempts_expired;

         rx_ep_timer u_timer (
            .clk_sys(clk_sys),
            .rst(rst),
            .tif(tif)
         );

         // interrupt causes; with dma in whole-transfer mode packets stay quiet
         assign irq_cause[n] = (ev_packet_rx[n]
                                && !(dma_request_enable[n] && dma_interrupt_mode[n]))
                               || (host_mode && ev_stall_rx[n])
                               || attempts_expired[n]
                               || (ev_dma_done[n] && dma_request_enable[n]
                                   && dma_interrupt_mode[n]);

         // payload register: only eleven bits are stored
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               max_payload_bytes[n] <= RST_MAX_PAYLOAD;
            end else if (wr_payload[n]) begin
               max_payload_bytes[n] <= reg_wdata[PAYLOAD_W-1:0];
            end
         end

         // sticky status flags; software clears by writing zero, hardware set wins
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               stalled[n] <= 1'b0;
               nak_timeout_flag[n] <= 1'b0;
               data_fault[n] <= 1'b0;
               rx_packet_ready[n] <= 1'b0;
            end else begin
               stalled[n] <= (host_mode ? ev_stall_rx[n] : ev_stall_tx[n])
                             | (stalled[n] & ~(wr_low[n] & ~reg_wdata[LOW_STALLED]));
               nak_timeout_flag[n] <= nak_expired[n]
                                      | (nak_timeout_flag[n] & ~tif.restart);
               data_fault[n] <= attempts_expired[n]
                                | (data_fault[n] & ~(wr_low[n] & ~reg_wdata[LOW_FAULT]));
               rx_packet_ready[n] <= next_ready[n];
            end
         end

         // request bit in host mode, send-stall bit in device mode
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               request_bit[n] <= 1'b0;
               stall_bit[n] <= 1'b0;
            end else begin
               if (ev_packet_rx[n]) begin
                  request_bit[n] <= 1'b0;
               end else if (wr_low[n] && host_mode) begin
                  request_bit[n] <= reg_wdata[LOW_REQUEST];
               end else if (ready_fall[n] && auto_request[n] && host_mode) begin
                  request_bit[n] <= 1'b1;
               end
               if (wr_low[n] && !host_mode) begin
                  stall_bit[n] <= reg_wdata[LOW_SEND_STALL];
               end
            end
         end

         // high register controls; a short packet cancels auto-request
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               auto_clear_ready[n] <= 1'b0;
               auto_request[n] <= 1'b0;
               dma_request_enable[n] <= 1'b0;
               dma_interrupt_mode[n] <= 1'b0;
            end else begin
               if (wr_high[n]) begin
                  auto_clear_ready[n] <= reg_wdata[HIGH_AUTO_CLEAR];
                  dma_request_enable[n] <= reg_wdata[HIGH_DMA_ENABLE];
                  dma_interrupt_mode[n] <= reg_wdata[HIGH_DMA_MODE];
               end
               if (ev_short_packet[n]) begin
                  auto_request[n] <= 1'b0;
               end else if (wr_high[n]) begin
                  auto_request[n] <= reg_wdata[HIGH_AUTO_REQUEST];
               end
            end
         end

         // data toggle: software clear and guarded load take precedence over the link
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               toggle[n] <= 1'b0;
            end else if (w_clear_toggle[n]) begin
               toggle[n] <= 1'b0;
            end else if (w_toggle_load[n]) begin
               toggle[n] <= reg_wdata[HIGH_TOGGLE];
            end else if (ev_toggle_flip[n]) begin
               toggle[n] <= ~toggle[n];
            end
         end

         // bytes unloaded from the current packet; restarts whenever ready drops
         always_ff @(posedge clk_sys) begin
            if (rst || !next_ready[n] || full_unload[n]) begin
               unloaded[n] <= '0;
            end else if (fifo_read[n]) begin
               unloaded[n] <= unloaded[n] + UNLOAD_W'(fifo_read_bytes);
            end
         end

         // the toggle flop drives the pin directly, so a change shows one cycle after its cause
         assign data_toggle_bit[n] = toggle[n];

         // registered outputs; a halted endpoint issues no further requests
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               request_in_packet[n] <= 1'b0;
               send_stall[n] <= 1'b0;
               fifo_flush[n] <= 1'b0;
               dma_request[n] <= 1'b0;
               endpoint_irq_flag[n] <= 1'b0;
            end else begin
               request_in_packet[n] <= host_mode && request_bit[n]
                                       && !nak_timeout_flag[n];
               send_stall[n] <= !host_mode && stall_bit[n];
               fifo_flush[n] <= w_flush[n];
               dma_request[n] <= dma_request_enable[n] && rx_packet_ready[n];
               endpoint_irq_flag[n] <= irq_cause[n];
            end
         end
      end
   endgenerate

   // read mux; the low register shows host or device fields by mode
   logic [7:0] low_view;
   logic [7:0] high_view;
   logic [PAYLOAD_W-1:0] payload_view;
   logic [1:0] ep_idx;

   assign ep_idx = (sel_ep == 2'h0) ? 2'h0 : sel_ep - 2'h1;
   assign payload_view = max_payload_bytes[ep_idx];
   assign low_view = {1'b0, stalled[ep_idx],
                      host_mode ? request_bit[ep_idx] : stall_bit[ep_idx],
                      1'b0,
                      host_mode & nak_timeout_flag[ep_idx],
                      host_mode & data_fault[ep_idx],
                      fifo_full[ep_idx],
                      rx_packet_ready[ep_idx]};
   assign high_view = {auto_clear_ready[ep_idx],
                       host_mode & auto_request[ep_idx],
                       dma_request_enable[ep_idx], 1'b0,
                       dma_interrupt_mode[ep_idx], 1'b0,
                       toggle[ep_idx], 1'b0};

   always_comb begin
      next_rdata = 16'h0000;
      if (reg_read && addr_ok) begin
         unique case (sel_reg)
            REG_MAX_PAYLOAD: next_rdata = {5'h00, payload_view};
            REG_CTRL_LOW: next_rdata = {8'h00, low_view};
            default: next_rdata = {8'h00, high_view};
         endcase
      end
   end

   // read data stands only in the cycle after the read strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule

// ===== verification/rx_ep_ctrl_properties.sv
/*
 * timing and field checks on the receive endpoint block: read data and payload upper bits at any address, all other checks on endpoint 1 only.
 * assumes the register map of rx_ep_pkg and one clock domain with sync reset.
 */
`timescale 1ns/1ps
module rx_ep_ctrl_properties
   import rx_ep_pkg::*;
#(
   parameter int EPS = NUM_EP
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic host_mode,
   input wire logic [EPS-1:0] ev_packet_rx,
   input wire logic [EPS-1:0] ev_toggle_flip,
   input wire logic [EPS-1:0] ev_stall_rx,
   input wire logic [EPS-1:0] ev_attempt_fail,
   input wire logic [EPS-1:0] ev_dma_done,
   input wire logic [EPS-1:0] request_in_packet,
   input wire logic [EPS-1:0] send_stall,
   input wire logic [EPS-1:0] fifo_flush,
   input wire logic [EPS-1:0] data_toggle_bit,
   input wire logic [EPS-1:0] endpoint_irq_flag
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // write decodes for endpoint 1
   wire logic low_wr = reg_write && reg_addr == 8'h14;
   wire logic high_wr = reg_write && reg_addr == 8'h18;
   wire logic flush_wr = low_wr && reg_wdata[LOW_FLUSH];
   wire logic no_flip = !ev_toggle_flip[0];

   // an isolated flush write, so a back-to-back pair does not look like a stuck pulse
   sequence lone_flush;
      flush_wr ##1 !flush_wr;
   endsequence
   sequence one_cycle_flush;
      fifo_flush[0] ##1 !fifo_flush[0];
   endsequence

   rdata_idle_a: assert property (!reg_read |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside the read answer cycle");
   payload_upper_a: assert property (reg_read && reg_addr[3:0] == 4'h0
      |=> reg_rdata[15:11] == 5'h00)
      else $error("payload upper bits not zero");
   stall_irq_a: assert property (host_mode && ev_stall_rx[0] |=> endpoint_irq_flag[0])
      else $error("stall received without interrupt");
   request_drop_a: assert property (ev_packet_rx[0] |=> ##1 !request_in_packet[0])
      else $error("request still out after packet");
   host_no_stall_a: assert property (host_mode |=> !send_stall[0])
      else $error("send stall driven in host mode");
   flush_pulse_a: assert property (lone_flush |-> one_cycle_flush)
      else $error("flush pulse missing or too long");
   flush_quiet_a: assert property (!flush_wr |=> !fifo_flush[0])
      else $error("flush pulse without flush write");
   toggle_clear_a: assert property (low_wr && reg_wdata[LOW_CLEAR_TOGGLE] && no_flip
      |=> !data_toggle_bit[0])
      else $error("toggle not cleared");
   toggle_load_a: assert property (high_wr && reg_wdata[HIGH_TOGGLE_WE] && no_flip
      |=> data_toggle_bit[0] == $past(reg_wdata[HIGH_TOGGLE]))
      else $error("toggle not loaded");
   toggle_hold_a: assert property (high_wr && !reg_wdata[HIGH_TOGGLE_WE] && no_flip
      |=> $stable(data_toggle_bit[0]))
      else $error("toggle written without write enable");
   irq_cause_a: assert property (endpoint_irq_flag[0]
      |-> $past(ev_packet_rx[0] || ev_stall_rx[0] || ev_dma_done[0])
      || $past(ev_attempt_fail[0], 2))
      else $error("interrupt without cause");
endmodule

bind rx_ep_ctrl rx_ep_ctrl_properties #(.EPS(EPS)) i_rx_ep_ctrl_properties (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .host_mode(host_mode),
   .ev_packet_rx(ev_packet_rx), .ev_toggle_flip(ev_toggle_flip), .ev_stall_rx(ev_stall_rx),
   .ev_attempt_fail(ev_attempt_fail), .ev_dma_done(ev_dma_done),
   .request_in_packet(request_in_packet), .send_stall(send_stall), .fifo_flush(fifo_flush),
   .data_toggle_bit(data_toggle_bit), .endpoint_irq_flag(endpoint_irq_flag));

// ===== verification/usb_link_peer.sv
/*
 * link-side model: frame ticks, one-cycle link events and fifo unload pulses.
 * assumes the bench calls its tasks right after a rising clock edge.
 */
`timescale 1ns/1ps
module usb_link_peer #(
   parameter int FRAME = 20
)
(
   input wire logic clk_sys,
   input wire logic rst,
   output logic frame_tick,
   output logic [7:0][2:0] ev,
   output logic [2:0] fifo_full,
   output logic [2:0] fifo_read,
   output logic [2:0] fifo_read_bytes
);
   int frame_cnt;

   // frame marker runs free, like start-of-frame on the bus
   always_ff @(posedge clk_sys) begin
      frame_cnt <= (rst || frame_cnt == FRAME - 1) ? 0 : frame_cnt + 1;
      frame_tick <= !rst && frame_cnt == FRAME - 1;
   end

   initial begin
      ev = '0;
      fifo_full = 3'b000;
      fifo_read = 3'b000;
      fifo_read_bytes = 3'h7;
   end
   // kinds: packet, short, flip, stall in, stall out, nak, failed try, dma done
   task automatic pulse(input logic [7:0] kinds, input logic [2:0] eps);
      for (int k = 0; k < 8; k++)
         ev[k] <= kinds[k] ? eps : 3'b000;
      @(posedge clk_sys);
      ev <= '0;
      @(posedge clk_sys);
   endtask

   // byte count is out of range between unloads so a stale value cannot count
   task automatic unload(input logic [2:0] eps, input logic [2:0] bytes);
      fifo_read <= eps;
      fifo_read_bytes <= bytes;
      @(posedge clk_sys);
      fifo_read <= 3'b000;
      fifo_read_bytes <= 3'h7;
      @(posedge clk_sys);
   endtask

   task automatic set_full(input logic [2:0] eps);
      fifo_full <= eps;
   endtask
endmodule

// ===== verification/usb_rx_endpoint_ctrl_test.sv
/*
 * register-level bench for the receive endpoint block with a link-side model.
 * assumes the 10 MHz clock, sync reset and the register map of rx_ep_pkg.
 */
`timescale 1ns/1ps
module usb_rx_endpoint_ctrl_test;
   import rx_ep_pkg::*;
   logic clk_sys, rst, reg_write, reg_read, host_mode;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [2:0] ep_bulk, ep_bulk_or_int, request_in_packet, send_stall, fifo_flush;
   logic [2:0] data_toggle_bit, dma_request, endpoint_irq_flag;
   logic [23:0] nak_limit;
   wire logic frame_tick;
   wire logic [7:0][2:0] ev;
   wire logic [2:0] fifo_full, fifo_read, fifo_read_bytes;
   int bad_count, check_count, irq_seen, k, n;

   rx_ep_ctrl i_rx_ep_ctrl (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .host_mode(host_mode), .frame_tick(frame_tick),
      .ep_bulk(ep_bulk), .ep_bulk_or_int(ep_bulk_or_int), .nak_limit(nak_limit),
      .ev_packet_rx(ev[0]), .ev_short_packet(ev[1]), .ev_toggle_flip(ev[2]),
      .ev_stall_rx(ev[3]), .ev_stall_tx(ev[4]), .ev_nak_rx(ev[5]), .ev_attempt_fail(ev[6]),
      .ev_dma_done(ev[7]), .fifo_full(fifo_full), .fifo_read(fifo_read),
      .fifo_read_bytes(fifo_read_bytes), .request_in_packet(request_in_packet),
      .send_stall(send_stall), .fifo_flush(fifo_flush), .data_toggle_bit(data_toggle_bit),
      .dma_request(dma_request), .endpoint_irq_flag(endpoint_irq_flag));

   usb_link_peer i_usb_link_peer (.clk_sys(clk_sys), .rst(rst), .frame_tick(frame_tick),
      .ev(ev), .fifo_full(fifo_full), .fifo_read(fifo_read),
      .fifo_read_bytes(fifo_read_bytes));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // interrupt pulses of endpoint 1, counted for the interrupt-mode tests
   always @(posedge clk_sys)
      if (endpoint_irq_flag[0] === 1'b1)
         irq_seen++;

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      check_count++;
      if (seen !== want) begin
         bad_count++;
         $display("BAD at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask

   // a gap cycle after each access keeps strobes from being driven twice in one step
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] want);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(negedge clk_sys);
      check(reg_rdata, want);
      @(posedge clk_sys);
   endtask

   // outputs are read mid-cycle: 0 request, 1 stall, 2 dma, 3 interrupts since k
   task automatic port(input int which, input logic [15:0] want);
      @(negedge clk_sys);
      check((which == 0) ? 16'(request_in_packet) : (which == 1) ? 16'(send_stall)
            : (which == 2) ? 16'(dma_request) : 16'(irq_seen - k), want);
      @(posedge clk_sys);
   endtask

   task automatic results();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      host_mode = 1'b1;
      ep_bulk = 3'b001;
      ep_bulk_or_int = 3'b001;
      nak_limit = 24'h00_0000;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int e = 1; e <= 3; e++)
         for (int r = 0; r < 3; r++)
            rd(8'(e * 16 + r * 4), 16'h0000);
      wr(8'h0c, 16'hffff);
      rd(8'h0c, 16'h0000);
      for (int e = 1; e <= 3; e++)
         wr(8'(e * 16), 16'hf800 | 16'(e * 2));
      for (int e = 1; e <= 3; e++)
         rd(8'(e * 16), 16'(e * 2));
      wr(8'h10, 16'h0400);
      rd(8'h10, 16'h0400);
      $display("reset values and payload done");
      wr(8'h14, 16'h0020);
      port(0, 16'h0001);
      k = irq_seen;
      i_usb_link_peer.pulse(8'h01, 3'b001);
      port(3, 16'h0001);
      rd(8'h14, 16'h0001);
      wr(8'h14, 16'h0000);
      fork
         i_usb_link_peer.pulse(8'h01, 3'b001);
         wr(8'h14, 16'h0000);
      join
      rd(8'h14, 16'h0001);
      wr(8'h14, 16'h0011);
      rd(8'h14, 16'h0000);
      $display("request, ready and flush done");
      wr(8'h10, 16'h0008);
      wr(8'h18, 16'h00c0);
      i_usb_link_peer.pulse(8'h01, 3'b001);
      i_usb_link_peer.unload(3'b001, 3'h4);
      rd(8'h14, 16'h0001);
      i_usb_link_peer.unload(3'b001, 3'h4);
      rd(8'h14, 16'h0020);
      i_usb_link_peer.pulse(8'h03, 3'b001);
      rd(8'h18, 16'h0080);
      wr(8'h14, 16'h0000);
      $display("auto clear and auto request done");
      i_usb_link_peer.pulse(8'h08, 3'b001);
      rd(8'h14, 16'h0040);
      wr(8'h14, 16'h0000);
      rd(8'h14, 16'h0000);
      i_usb_link_peer.pulse(8'h40, 3'b001);
      i_usb_link_peer.pulse(8'h40, 3'b001);
      rd(8'h14, 16'h0000);
      i_usb_link_peer.pulse(8'h40, 3'b001);
      rd(8'h14, 16'h0004);
      wr(8'h14, 16'h0000);
      i_usb_link_peer.set_full(3'b001);
      rd(8'h14, 16'h0002);
      i_usb_link_peer.set_full(3'b000);
      rd(8'h14, 16'h0000);
      $display("stall, fault and full done");
      wr(8'h18, 16'h0000);
      i_usb_link_peer.pulse(8'h04, 3'b001);
      rd(8'h18, 16'h0002);
      wr(8'h14, 16'h0080);
      rd(8'h18, 16'h0000);
      wr(8'h18, 16'h0006);
      rd(8'h18, 16'h0002);
      wr(8'h18, 16'h0000);
      rd(8'h18, 16'h0002);
      $display("toggle done");
      nak_limit <= 24'h00_0002;
      wr(8'h14, 16'h0020);
      port(0, 16'h0001);
      i_usb_link_peer.pulse(8'h20, 3'b001);
      for (n = 0; n < 200 && request_in_packet[0] !== 1'b0; n++)
         @(posedge clk_sys);
      if (n == 200) begin
         bad_count++;
         $display("BAD at %0t: endpoint never halted", $time);
         results();
      end
      rd(8'h14, 16'h0028);
      wr(8'h14, 16'h0020);
      port(0, 16'h0001);
      wr(8'h14, 16'h0000);
      nak_limit <= 24'h00_0000;
      $display("nak timeout done");
      host_mode <= 1'b0;
      wr(8'h14, 16'h0020);
      port(1, 16'h0001);
      i_usb_link_peer.pulse(8'h10, 3'b001);
      rd(8'h14, 16'h0060);
      wr(8'h14, 16'h0000);
      port(1, 16'h0000);
      wr(8'h18, 16'h0020);
      i_usb_link_peer.pulse(8'h01, 3'b001);
      port(2, 16'h0001);
      wr(8'h14, 16'h0000);
      port(2, 16'h0000);
      wr(8'h18, 16'h0028);
      k = irq_seen;
      i_usb_link_peer.pulse(8'h01, 3'b001);
      port(3, 16'h0000);
      i_usb_link_peer.pulse(8'h80, 3'b001);
      port(3, 16'h0001);
      $display("device stall and dma done");
      results();
   end
endmodule
